// [hdl/wdg_top.sv]
// Watchdog unit: timeout counter on a 256 Hz tick, overflow action
// (non-maskable interrupt or reset request), AXI4-Lite registers.
// Assumes tick_256hz comes from the oscillator divider on its own clock
// and stops in sleep; halt does not stop it.
//
// Contract
// - If not serviced within 131,072 oscillator periods the unit requests an NMI or a reset.
// - The counter advances on the 256 Hz tick, the oscillator divided by 128, gated only by the run key.
// - Status bit 1 selects the overflow action: 0 (default) NMI, 1 reset.
// - The counter is stopped while the run key holds 0b1010 and runs for any other value.
// - Reset loads the run key with 0b1010, so the unit starts stopped.
// - Writing 1 to control bit 4 clears the counter and starts a new period; 0 does nothing.
// - The service bit always reads as 0.
// - An unserviced overflow sets the read-only status flag at bit 0.
// - A service clears the status flag.
// - The flag is also set in reset mode and is then cleared by the reset that follows.
// - Counting continues in halt, so an overflow ends halt.
// - Counting stops in sleep, when the tick is absent, and the count is kept.
// - Reserved bits read as 0 and software writes them only as 0.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module wdg_top
  import wdg_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Oscillator tick
  input  wire logic              tick_256hz,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Requests to the CPU core
  output logic                   nmi_req,
  output logic                   reset_req,
  output logic                   irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  wdg_state_t        s;
  wdg_state_t        next_s;
  logic              tick_evt;
  logic              running;
  logic              wr_fire;
  logic              svc_wr;
  logic              ovf_evt;
  logic [ADDR_W-1:0] wa;
  logic [7:0]        wd;
  logic              wl0;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_s = s;

    // Tick filter: edge counts once the 2nd and 3rd stages agree
    next_s.tsync = {s.tsync[1:0], tick_256hz};
    tick_evt = (s.tsync[2] == s.tsync[1]) && s.tsync[2] && !s.tlvl;
    if (s.tsync[2] == s.tsync[1])
    begin
      next_s.tlvl = s.tsync[2];
    end

    // Write channels are taken independently, in either order
    if (awvalid && s.awready)
    begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_got  = 1'b1;
      next_s.wbyte  = wdata[7:0];
      next_s.wlane0 = wstrb[0];
    end
    wr_fire = next_s.aw_got && next_s.w_got;
    wa      = next_s.aw_addr;
    wd      = next_s.wbyte;
    wl0     = next_s.wlane0;
    svc_wr  = wr_fire && wl0 && (wa == CTL_ADDR) && wd[SVC_BIT];

    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // Watchdog counter
    running = (s.run_key != RUN_STOP);
    // Tick keeps arriving in halt; in sleep it is absent, count holds
    ovf_evt = running && tick_evt && (s.cnt == CNT_LAST) && !svc_wr;
    next_s.nmi     = ovf_evt && !s.mode;
    next_s.rst_req = ovf_evt && s.mode;
    if (svc_wr)
    begin
      next_s.cnt  = '0;
      next_s.flag = 1'b0;
    end
    else if (running && tick_evt)
    begin
      // Clear at the timeout so the next period is a full one
      next_s.cnt = ovf_evt ? '0 : s.cnt + 1'b1;
    end

    // Register writes; reserved bits are dropped
    if (wr_fire)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      if (wl0)
      begin
        unique case (wa)
          CTL_ADDR:  next_s.run_key = wd[3:0];
          ST_ADDR:   next_s.mode    = wd[MODE_BIT];
          ISTS_ADDR: next_s.ists    = s.ists & ~wd[OVF_BIT];
          IMSK_ADDR: next_s.imsk    = wd[OVF_BIT];
          default:   next_s.bresp   = RESP_SLVERR;
        endcase
      end
      else if (!(wa inside {CTL_ADDR, ST_ADDR, ISTS_ADDR, IMSK_ADDR}))
      begin
        next_s.bresp = RESP_SLVERR;
      end
    end

    // Hardware set wins over a clear in the same cycle
    if (ovf_evt)
    begin
      next_s.flag = 1'b1;
      next_s.ists = 1'b1;
    end
    next_s.irq = next_s.ists & next_s.imsk;

    // Read channel: one read in flight
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      unique case (araddr)
        CTL_ADDR:  next_s.rbyte = {4'h0, s.run_key};
        ST_ADDR:   next_s.rbyte = {6'h00, s.mode, s.flag};
        ISTS_ADDR: next_s.rbyte = {7'h00, s.ists};
        IMSK_ADDR: next_s.rbyte = {7'h00, s.imsk};
        default:
        begin
          next_s.rbyte = 8'h00;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s         <= '0;
      s.run_key <= CTL_RST[3:0];
      s.mode    <= ST_RST[MODE_BIT];
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign awready   = s.awready;
  assign wready    = s.wready;
  assign bvalid    = s.bvalid;
  assign bresp     = s.bresp;
  assign arready   = s.arready;
  assign rvalid    = s.rvalid;
  assign rdata     = {24'h000000, s.rbyte};
  assign rresp     = s.rresp;
  assign nmi_req   = s.nmi;
  assign reset_req = s.rst_req;
  assign irq       = s.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_ovf_nmi;
    (running && tick_evt && s.cnt == CNT_LAST && !svc_wr && !s.mode)
      |=> (nmi_req && !reset_req) ##1 !nmi_req;
  endproperty
  a_ovf_nmi: assert property (p_ovf_nmi)
    else $error("overflow in NMI mode gave no single NMI pulse");

  property p_ovf_rst;
    (running && tick_evt && s.cnt == CNT_LAST && !svc_wr && s.mode)
      |=> reset_req && !nmi_req && s.flag;
  endproperty
  a_ovf_rst: assert property (p_ovf_rst)
    else $error("overflow in reset mode gave no reset request");

  property p_stop;
    (s.run_key == RUN_STOP && !svc_wr) |=> $stable(s.cnt) && !nmi_req;
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_count;
    (running && tick_evt && !svc_wr && s.cnt != CNT_LAST)
      |=> s.cnt == $past(s.cnt) + 1'b1;
  endproperty
  a_count: assert property (p_count)
    else $error("counter did not advance on tick");

  property p_hold;
    (!tick_evt && !svc_wr) |=> $stable(s.cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without a tick");

  property p_svc;
    (svc_wr) |=> s.cnt == '0 && !s.flag && !nmi_req && !reset_req;
  endproperty
  a_svc: assert property (p_svc)
    else $error("service did not clear counter and flag");

  property p_flag;
    (s.flag && !svc_wr) |=> s.flag;
  endproperty
  a_flag: assert property (p_flag)
    else $error("status flag cleared without service");

  property p_set;
    $rose(s.flag) |-> nmi_req || reset_req;
  endproperty
  a_set: assert property (p_set)
    else $error("status flag set without an overflow");

  property p_rd_zero;
    (arvalid && arready && araddr == CTL_ADDR)
      |=> rvalid && rdata[7:4] == 4'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("service bit or reserved bits read as one");

  property p_resvd;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  a_resvd: assert property (p_resvd)
    else $error("reserved read bits not zero");

  property p_rst_val;
    !$past(nrst) |-> s.run_key == RUN_STOP && !s.flag && s.cnt == '0;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("wrong state after reset");

  property p_wrap;
    ovf_evt |=> s.cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not restart after the timeout");

  property p_one_act;
    ovf_evt |=> nmi_req != reset_req;
  endproperty
  a_one_act: assert property (p_one_act)
    else $error("overflow gave no single action");

  property p_rst_flag;
    reset_req |-> s.flag;
  endproperty
  a_rst_flag: assert property (p_rst_flag)
    else $error("reset request without the status flag");

  property p_st_resvd;
    (arvalid && arready && araddr == ST_ADDR)
      |=> rvalid && rdata[7:2] == 6'h00;
  endproperty
  a_st_resvd: assert property (p_st_resvd)
    else $error("status reserved bits read as one");

  property p_ovf_ists;
    ovf_evt |=> s.ists;
  endproperty
  a_ovf_ists: assert property (p_ovf_ists)
    else $error("overflow did not set the interrupt status");

  property p_cnt_max;
    s.cnt <= CNT_LAST;
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("counter ran past the timeout");

  property p_stop_rst;
    (s.run_key == RUN_STOP) |=> !reset_req;
  endproperty
  a_stop_rst: assert property (p_stop_rst)
    else $error("reset request while stopped");

  // Read data must stand until the master takes it
  property p_rhold;
    (rvalid && !rready) |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped before it was taken");

  c_nmi: cover property (nmi_req);
  c_rst: cover property (reset_req);
  c_svc_run: cover property (svc_wr && running);
  c_irq: cover property (irq);
  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);

endmodule : wdg_top

// [hdl/wdg_pkg.sv]
// Constants, register map and state layout of the watchdog unit.
// Assumes a 32-bit AXI4-Lite master and a 256 Hz tick from the
// low-speed oscillator divider, asynchronous to ref_clk.
package wdg_pkg;

  // ****************************************************************
  // Register map: printed offsets are word indices
  // ****************************************************************
  localparam int          ADDR_W    = 18;
  localparam logic [15:0] CTL_IDX   = 16'h5040;
  localparam logic [15:0] ST_IDX    = 16'h5041;
  localparam logic [15:0] ISTS_IDX  = 16'h5042;
  localparam logic [15:0] IMSK_IDX  = 16'h5043;
  localparam logic [ADDR_W-1:0] CTL_ADDR  = {CTL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] ST_ADDR   = {ST_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] ISTS_ADDR = {ISTS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IMSK_ADDR = {IMSK_IDX, 2'b00};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         SVC_BIT   = 4;
  localparam int         MODE_BIT  = 1;
  localparam int         FLAG_BIT  = 0;
  localparam int         OVF_BIT   = 0;
  localparam logic [3:0] RUN_STOP  = 4'ha;
  localparam logic [7:0] CTL_RST   = 8'h0a;
  localparam logic [7:0] ST_RST    = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing in oscillator periods and ticks
  // ****************************************************************
  localparam int OSC_PERIODS   = 131072;
  localparam int OSC_DIV       = 128;
  localparam int TIMEOUT_TICKS = OSC_PERIODS / OSC_DIV;
  localparam int CNT_W         = 15;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_TICKS - 1);

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [7:0]        wbyte;
    logic              wlane0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [7:0]        rbyte;
    logic [1:0]        rresp;
    logic [2:0]        tsync;
    logic              tlvl;
    logic [3:0]        run_key;
    logic              mode;
    logic              flag;
    logic [CNT_W-1:0]  cnt;
    logic              nmi;
    logic              rst_req;
    logic              ists;
    logic              imsk;
    logic              irq;
  } wdg_state_t;

endpackage : wdg_pkg

// [verification/wdg_cpu_model.sv]
// CPU core model: counts watchdog requests, answers a reset request.
// Assumes one-cycle request pulses on ref_clk.
`timescale 1ns/10ps
module wdg_cpu_model (
  // Clock and requests
  input  wire logic ref_clk,
  input  wire logic nmi_req,
  input  wire logic reset_req,
  // Counts seen and system reset back to the unit
  output int        nmi_seen,
  output int        rst_seen,
  output logic      core_nrst
);
  int hold;

  initial
  begin
    nmi_seen = 0;
    rst_seen = 0;
    core_nrst = 1'b1;
    hold = 0;
  end

  // A reset request pulls the system reset low for four cycles
  always @(posedge ref_clk)
  begin
    if (nmi_req === 1'b1)
      nmi_seen <= nmi_seen + 1;
    if (reset_req === 1'b1)
    begin
      rst_seen <= rst_seen + 1;
      hold <= 4;
    end
    else if (hold > 0)
      hold <= hold - 1;
    core_nrst <= !(reset_req === 1'b1 || hold > 1);
  end
endmodule : wdg_cpu_model

// [verification/tb_top.sv]
// Self-checking bench of the watchdog unit with a CPU core model.
// Assumes ticks spaced 8 cycles apart and an AXI4-Lite master here.
`timescale 1ns/10ps
module tb_top
  import wdg_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              tb_nrst, nrst, core_nrst, tick_256hz, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_val;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, nmi_req, reset_req;
  logic [1:0]        bresp, rresp, resp;
  logic [3:0]        key;
  int                nmi_seen, rst_seen, sp;
  int                miscompares = 0;
  int                n_tests = 0;
  int                seed = 32'hf8b56c0d;

  always #2 ref_clk = ~ref_clk;
  assign nrst = tb_nrst & core_nrst;

  wdg_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .tick_256hz(tick_256hz),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .nmi_req(nmi_req),
    .reset_req(reset_req), .irq(irq));

  wdg_cpu_model cpu_u (.ref_clk(ref_clk), .nmi_req(nmi_req),
    .reset_req(reset_req), .nmi_seen(nmi_seen), .rst_seen(rst_seen),
    .core_nrst(core_nrst));

  task automatic close_out;
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : chk

  // One bus transfer; each channel held until its own ready
  task automatic xfer(input bit w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    @(posedge ref_clk);
    if (w)
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done)
    begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        bready <= 1'b0;
        resp = bresp;
        done = 1'b1;
      end
      if (rvalid === 1'b1)
      begin
        rready <= 1'b0;
        resp = rresp;
        rd_val = rdata;
        done = 1'b1;
      end
      if (n > 40)
      begin
        miscompares++;
        close_out();
      end
    end
  endtask : xfer

  task automatic rdc(input string nm, input logic [ADDR_W-1:0] a,
                     input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd_val, exp);
  endtask : rdc

  task automatic tick(input int cnt);
    repeat (cnt)
    begin
      @(posedge ref_clk) tick_256hz <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(posedge ref_clk) tick_256hz <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask : tick

  task automatic irq_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                         input logic [31:0] exp);
    xfer(1'b1, a, d);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'(irq), exp);
  endtask : irq_chk

  initial
  begin
    {tb_nrst, tick_256hz, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge ref_clk);
    tb_nrst <= 1'b1;
    rdc("ctl", CTL_ADDR, 32'h0000000a);
    rdc("st", ST_ADDR, 32'h0);
    rdc("hole", IMSK_ADDR + 18'h10, 32'h0);
    chk("hole resp", 32'(resp), 32'h2);
    xfer(1'b1, IMSK_ADDR + 18'h10, 32'h1);
    chk("hole bresp", 32'(resp), 32'h2);
    tick(1030);
    chk("stopped", 32'(nmi_seen), 32'h0);
    key = 4'($random(seed));
    if (key === 4'ha) key = 4'h5;
    xfer(1'b1, IMSK_ADDR, 32'h1);
    xfer(1'b1, CTL_ADDR, {27'h0, 1'b1, key});
    rdc("ctl run", CTL_ADDR, {28'h0, key});
    sp = 1 + ($random(seed) & 511);
    tick(sp);
    // Tick absent as in sleep; the count must be kept
    repeat (300) @(posedge ref_clk);
    xfer(1'b1, CTL_ADDR, {28'h0, key});
    tick(1023 - sp);
    chk("early", 32'(nmi_seen), 32'h0);
    tick(1);
    chk("nmi", 32'(nmi_seen), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rdc("flag", ST_ADDR, 32'h1);
    irq_chk(IMSK_ADDR, 32'h0, 32'h0);
    irq_chk(IMSK_ADDR, 32'h1, 32'h1);
    irq_chk(ISTS_ADDR, 32'h1, 32'h0);
    tick(1024);
    chk("wrap", 32'(nmi_seen), 32'h2);
    xfer(1'b1, CTL_ADDR, {27'h0, 1'b1, key});
    rdc("svc", ST_ADDR, 32'h0);
    xfer(1'b1, ST_ADDR, 32'h2);
    chk("mode bresp", 32'(resp), 32'h0);
    rdc("mode", ST_ADDR, 32'h2);
    tick(1024);
    chk("rst", 32'(rst_seen), 32'h1);
    chk("no nmi", 32'(nmi_seen), 32'h2);
    repeat (8) @(posedge ref_clk);
    rdc("st after", ST_ADDR, 32'h0);
    rdc("ctl after", CTL_ADDR, 32'h0000000a);
    close_out();
  end
endmodule : tb_top
